/* File: sfp_map.svh */
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH

// ****************************************************************
// register offsets, as seen on the register port
// ****************************************************************
`define SFP_OFS_SIZES      8'h3E
`define SFP_OFS_TALLY      8'h3F
`define SFP_OFS_LEVEL      8'h40
`define SFP_OFS_DROPS      8'h41

// ****************************************************************
// reset values and field limits
// ****************************************************************
`define SFP_SIZES_RST      32'h02222222
`define SFP_ZERO_WORD      32'h00000000
`define SFP_RSVD_MASK      32'h0FFFFFFF
`define SFP_CODE_MAX       4'h8
`define SFP_HW_PER_STEP    15'h0400
`define SFP_TALLY_W        9
`define SFP_LEVEL_W        14
`define SFP_DROPS_W        32

`endif

/* File: sfp_pkg.sv */
// ****************************************************************
// shared types of the queue partition and statistics block
// ****************************************************************
package sfp_pkg;

   // sizing register layout, msb first
   typedef struct packed {
      logic [3:0] reserved;                      // reads zero
      logic [3:0] cross_port_one_to_two_depth;   // bits 27:24
      logic [3:0] cross_port_two_to_one_depth;   // bits 23:20
      logic [3:0] port_two_urgent_rx_depth;      // bits 19:16
      logic [3:0] port_two_normal_rx_depth;      // bits 15:12
      logic [3:0] port_one_urgent_rx_depth;      // bits 11:8
      logic [3:0] port_one_normal_rx_depth;      // bits 7:4
      logic [3:0] host_outbound_depth;           // bits 3:0
   } sfp_sizes_t;

   // one register request from the serial port slave
   typedef struct packed {
      logic        wr;       // write strobe, one cycle
      logic        rd;       // read strobe, one cycle
      logic [7:0]  addr;     // register offset
      logic [31:0] wdata;    // write data
   } sfp_reg_req_t;

   // host transmit frame stream
   typedef struct packed {
      logic        sof;      // frame start, len valid
      logic        hw;       // one half-word arrives
      logic        eof;      // frame end
      logic [13:0] len;      // frame length in half-words
   } sfp_htx_t;

   // queue events from the switch core
   typedef struct packed {
      logic tx_enq;          // complete frame enters tx queue
      logic tx_deq;          // frame leaves tx queue
      logic htx_drain;       // one half-word leaves host queue
   } sfp_qev_t;

endpackage : sfp_pkg

/* File: sfp_updown.sv */
`include "sfp_map.svh"

// ****************************************************************
// saturating up/down counter with synchronous clear
// ****************************************************************
module sfp_updown #(
   parameter int WIDTH = 9                        // counter width
) (
   input  wire logic             sys_clk_in,      // core clock
   input  wire logic             srst_in,         // sync reset
   input  wire logic             clr_in,          // clear to zero
   input  wire logic             inc_in,          // count up
   input  wire logic             dec_in,          // count down
   output logic      [WIDTH-1:0] count_out        // current count
);

   logic [WIDTH-1:0] count_r;                     // count state
   logic [WIDTH-1:0] count_nxt;                   // next count

   // saturate both ways so a stray event never wraps the count
   always_comb
   begin
      count_nxt = count_r;
      if (clr_in)
      begin
         count_nxt = '0;
      end
      else if (inc_in && !dec_in && (count_r != '1))
      begin
         count_nxt = count_r + WIDTH'(1);
      end
      else if (dec_in && !inc_in && (count_r != '0))
      begin
         count_nxt = count_r - WIDTH'(1);
      end
   end

   // count register
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         count_r <= '0;
      end
      else
      begin
         count_r <= count_nxt;
      end
   end

   assign count_out = count_r;

endmodule : sfp_updown

/* File: sfp_queue_stats.sv */
`include "sfp_map.svh"

module sfp_queue_stats (
   input  wire logic                 sys_clk_in,     // core clock, 20 MHz
   input  wire logic                 srst_in,        // sync reset, high
   input  wire sfp_pkg::sfp_reg_req_t reg_req_in,    // register request
   output logic               [31:0] reg_rdata_out,  // read data
   output logic                      reg_ack_out,    // access done pulse
   input  wire logic                 queue_flush_in, // queue flush pulse
   input  wire sfp_pkg::sfp_htx_t    htx_in,         // host frame stream
   input  wire sfp_pkg::sfp_qev_t    qev_in,         // queue events
   output sfp_pkg::sfp_sizes_t       sizes_out       // sizes in force
);

   // ****************************************************************
   // decoding helpers
   // ****************************************************************

   // depth code to capacity in half-words; undefined codes clamp at max
   function automatic logic [14:0] sfp_capacity(input logic [3:0] code);
      logic [3:0] c;
      c = (code > `SFP_CODE_MAX) ? `SFP_CODE_MAX : code;
      return 15'(c) * `SFP_HW_PER_STEP;
   endfunction : sfp_capacity

   // offset match, used by the write and read decoders
   function automatic logic sfp_hit(input logic [7:0] addr, input logic [7:0] ofs);
      return addr == ofs;
   endfunction : sfp_hit

   // ****************************************************************
   // state
   // ****************************************************************
   // codes above eight are stored as written; only the capacity clamps
   sfp_pkg::sfp_sizes_t    sizes_r;                // sizing register
   logic                   flushed_r;              // flush seen, no traffic since
   logic                   frame_ok_r;             // current host frame accepted
   logic [`SFP_DROPS_W-1:0] drops_r;               // dropped host frames
   logic [31:0]            rdata_r;                // read data register
   logic                   ack_r;                  // ack register
   logic [`SFP_TALLY_W-1:0] tally;                 // tx frame count
   logic [`SFP_LEVEL_W-1:0] level;                 // host half-word level
   logic [14:0]            room_need;              // level plus new frame
   logic                   frame_fits;             // new frame fits
   logic                   htx_take;               // half-word stored
   logic                   traffic;                // admitted frame start or tx enqueue
   logic                   size_wr;                // write to sizing register

   // ****************************************************************
   // host frame admission
   // ****************************************************************

   // whole-frame check against the host queue size in force
   assign room_need  = 15'(level) + 15'(htx_in.len);
   assign frame_fits = room_need <= sfp_capacity(sizes_r.host_outbound_depth);
   assign htx_take   = htx_in.hw && (htx_in.sof ? frame_fits : frame_ok_r);
   assign traffic    = (htx_in.sof && frame_fits) || qev_in.tx_enq;
   assign size_wr    = reg_req_in.wr && sfp_hit(reg_req_in.addr, `SFP_OFS_SIZES);

   // remember whether the running frame was admitted
   // a flush forgets the frame in flight, so its tail is never counted
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in || queue_flush_in)
      begin
         frame_ok_r <= 1'b0;
      end
      else if (htx_in.sof)
      begin
         frame_ok_r <= frame_fits && !htx_in.eof;   // one-beat frame ends now
      end
      else if (htx_in.eof)
      begin
         frame_ok_r <= 1'b0;
      end
   end

   // overflow drops: one count per refused frame, never per half-word
   // saturates at all ones rather than wrapping back to zero
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         drops_r <= '0;
      end
      else if (htx_in.sof && !frame_fits && (drops_r != '1))
      begin
         drops_r <= drops_r + `SFP_DROPS_W'(1);
      end
   end

   // ****************************************************************
   // occupancy counters
   // ****************************************************************

   // complete frames waiting in the tx queue; a flush empties it
   sfp_updown #(
      .WIDTH      (`SFP_TALLY_W)
   ) u_tally (
      .sys_clk_in (sys_clk_in),
      .srst_in    (srst_in),
      .clr_in     (queue_flush_in),
      .inc_in     (qev_in.tx_enq),
      .dec_in     (qev_in.tx_deq),
      .count_out  (tally)
   );

   // valid half-words in the host queue; admitted beats only
   // a drain of an empty queue is ignored by the saturating counter
   sfp_updown #(
      .WIDTH      (`SFP_LEVEL_W)
   ) u_level (
      .sys_clk_in (sys_clk_in),
      .srst_in    (srst_in),
      .clr_in     (queue_flush_in),
      .inc_in     (htx_take),
      .dec_in     (qev_in.htx_drain),
      .count_out  (level)
   );

   // ****************************************************************
   // sizing register
   // ****************************************************************

   // flush opens the sizing register; frame traffic closes it again.
   // set wins so a flush in the same cycle as traffic is not lost.
   // drains and dequeues alone do not close it; only new frames do.
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         flushed_r <= 1'b0;
      end
      else if (queue_flush_in)
      begin
         flushed_r <= 1'b1;
      end
      else if (traffic)
      begin
         flushed_r <= 1'b0;
      end
   end

   // writes outside a flushed window are ignored; resizing live queues
   // would corrupt frames already stored across partition boundaries
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         sizes_r <= `SFP_SIZES_RST;
      end
      else if (size_wr && flushed_r)
      begin
         // fields land in place; reserved nibble forced zero
         sizes_r <= reg_req_in.wdata & `SFP_RSVD_MASK;
      end
   end

   // ****************************************************************
   // register read path
   // ****************************************************************

   // one-cycle registered answer; unmapped offsets read zero
   // should both be raised the read answers and the write still lands; the port never does both
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         rdata_r <= `SFP_ZERO_WORD;
         ack_r   <= 1'b0;
      end
      else
      begin
         ack_r <= reg_req_in.rd || reg_req_in.wr;
         if (!reg_req_in.rd)
         begin
            rdata_r <= `SFP_ZERO_WORD;        // idle data held at zero
         end
         else if (sfp_hit(reg_req_in.addr, `SFP_OFS_SIZES))
         begin
            rdata_r <= sizes_r;
         end
         else if (sfp_hit(reg_req_in.addr, `SFP_OFS_TALLY))
         begin
            rdata_r <= 32'(tally);
         end
         else if (sfp_hit(reg_req_in.addr, `SFP_OFS_LEVEL))
         begin
            rdata_r <= 32'(level);
         end
         else if (sfp_hit(reg_req_in.addr, `SFP_OFS_DROPS))
         begin
            rdata_r <= drops_r;
         end
         else
         begin
            rdata_r <= `SFP_ZERO_WORD;        // unmapped
         end
      end
   end

   assign reg_rdata_out = rdata_r;
   assign reg_ack_out   = ack_r;
   assign sizes_out     = sizes_r;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (srst_in);

   chk_sizes_reset_val: assert property ($fell(srst_in) |-> sizes_r == `SFP_SIZES_RST)
      else $error("sizing register not at reset value");

   chk_reserved_nibble: assert property (sizes_r.reserved == 4'h0)
      else $error("reserved sizing bits not zero");

   chk_write_refused: assert property (size_wr && !flushed_r |=> $stable(sizes_r))
      else $error("sizing write taken without flush");

   chk_write_taken: assert property (size_wr && flushed_r |=>
      sizes_r == ($past(reg_req_in.wdata) & `SFP_RSVD_MASK))
      else $error("sizing write not applied");

   chk_drop_count_one: assert property (htx_in.sof && !frame_fits && drops_r != '1 |=>
      drops_r == $past(drops_r) + `SFP_DROPS_W'(1))
      else $error("drop count not raised by one");

   chk_drop_count_idle: assert property (!htx_in.sof |=> $stable(drops_r))
      else $error("drop count moved without frame");

   chk_flush_empties: assert property (queue_flush_in |=> tally == '0 && level == '0)
      else $error("flush left queue counts");

   chk_dropped_beats: assert property (htx_in.hw && !htx_in.sof && !frame_ok_r && !qev_in.htx_drain
      && !queue_flush_in |=> $stable(level))
      else $error("dropped frame data counted");

   chk_tally_read: assert property (reg_req_in.rd && reg_req_in.addr == `SFP_OFS_TALLY |=>
      reg_ack_out && reg_rdata_out == 32'($past(tally)))
      else $error("tally read wrong");

   chk_sizes_out_follow: assert property (size_wr && flushed_r |=>
      sizes_out == ($past(reg_req_in.wdata) & `SFP_RSVD_MASK))
      else $error("sizes output not updated");

   // read answers: each register seen one cycle after its strobe
   chk_sizes_read: assert property (reg_req_in.rd && reg_req_in.addr == `SFP_OFS_SIZES |=>
      reg_ack_out && reg_rdata_out == 32'($past(sizes_r)))
      else $error("sizing register read wrong");

   chk_level_read: assert property (reg_req_in.rd && reg_req_in.addr == `SFP_OFS_LEVEL |=>
      reg_ack_out && reg_rdata_out == 32'($past(level)))
      else $error("level read wrong");

   chk_drops_read: assert property (reg_req_in.rd && reg_req_in.addr == `SFP_OFS_DROPS |=>
      reg_ack_out && reg_rdata_out == $past(drops_r))
      else $error("drop count read wrong");

   // counter steps: one event moves a count by exactly one
   chk_tally_rises: assert property (qev_in.tx_enq && !qev_in.tx_deq
      && !queue_flush_in && tally != '1 |=> tally == $past(tally) + `SFP_TALLY_W'(1))
      else $error("tally not raised by one");

   chk_tally_falls: assert property (qev_in.tx_deq && !qev_in.tx_enq
      && !queue_flush_in && tally != '0 |=> tally == $past(tally) - `SFP_TALLY_W'(1))
      else $error("tally not lowered by one");

   chk_level_rises: assert property (htx_take && !qev_in.htx_drain
      && !queue_flush_in && level != '1 |=> level == $past(level) + `SFP_LEVEL_W'(1))
      else $error("level not raised by one");

   chk_level_drains: assert property (qev_in.htx_drain && !htx_take
      && !queue_flush_in && level != '0 |=> level == $past(level) - `SFP_LEVEL_W'(1))
      else $error("level not lowered by one");

   chk_refused_sof: assert property (htx_in.sof && !frame_fits && !qev_in.htx_drain
      && !queue_flush_in |=> $stable(level))
      else $error("refused frame start counted");

   chk_flush_opens: assert property (queue_flush_in |=> flushed_r)
      else $error("flush did not open sizing register");

endmodule : sfp_queue_stats

/* File: sfp_placeholder_unused.sv */
// ****************************************************************
// intentionally empty
// ****************************************************************

/* File: sfp_host_model.sv */
// ****************************************************************
// host controller model on the register port
// ****************************************************************
module sfp_host_model (
   input  wire logic                 sys_clk_in,    // core clock
   output sfp_pkg::sfp_reg_req_t     reg_req_out,   // register request
   input  wire logic          [31:0] reg_rdata_in,  // read data
   input  wire logic                 reg_ack_in,    // access done pulse
   output logic                      flush_out      // queue flush pulse
);
   timeunit 1ns;
   timeprecision 100ps;

   // idle request and no flush from time zero
   initial
   begin
      reg_req_out = '0;
      flush_out   = 1'b0;
   end

   // one access: drive after an edge, take the answer one edge later
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic k);
      @(posedge sys_clk_in);
      #1;
      reg_req_out = '{wr: w, rd: ~w, addr: a, wdata: d};
      @(posedge sys_clk_in);
      #1;
      q = reg_rdata_in;
      k = reg_ack_in;
      // released lines show the inverse, so stale values never match
      reg_req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask : xfer

   // one-cycle flush pulse
   task automatic flush;
      @(posedge sys_clk_in);
      #1;
      flush_out = 1'b1;
      @(posedge sys_clk_in);
      #1;
      flush_out = 1'b0;
   endtask : flush

   // resize: called only with traffic halted, queues empty and all frames discarded
   // flush first, then the new sizes; callers keep codes at most 8, sum within 28 kB
   task automatic resize(input logic [31:0] s);
      logic [31:0] q;
      logic        k;
      flush();
      xfer(1'b1, 8'h3E, s, q, k);
   endtask : resize

endmodule : sfp_host_model

/* File: tb.sv */
// ****************************************************************
// self-checking bench of the queue partition and statistics block
// ****************************************************************
module tb;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct {
      logic        w;                   // write when high
      logic [7:0]  a;                   // offset
      logic [31:0] d;                   // write data
      logic [31:0] e;                   // expected read data
   } sfp_tb_row_t;

   logic                  sys_clk_in = 1'b0;  // 20 MHz clock
   logic                  srst_in    = 1'b1;  // sync reset
   sfp_pkg::sfp_reg_req_t req;                // from host model
   logic           [31:0] rdata;              // read data
   logic                  ack;                // access done
   logic                  flush;              // flush pulse
   sfp_pkg::sfp_htx_t     htx = '0;           // host frame stream
   sfp_pkg::sfp_qev_t     qev = '0;           // queue events
   sfp_pkg::sfp_sizes_t   sizes;              // sizes in force
   int                    n_fail = 0;         // mismatches
   int                    num_checks = 0;     // comparisons
   logic           [31:0] q;                  // last read data
   logic                  k;                  // last ack

   // plain accesses after reset: writes to closed or read-only places change nothing
   sfp_tb_row_t rows [10] = '{
      '{1'b0, 8'h3E, 32'h00000000, 32'h02222222},
      '{1'b1, 8'h3E, 32'h01111111, 32'h00000000},
      '{1'b0, 8'h3E, 32'h00000000, 32'h02222222},
      '{1'b1, 8'h3F, 32'hFFFFFFFF, 32'h00000000},
      '{1'b0, 8'h3F, 32'h00000000, 32'h00000000},
      '{1'b1, 8'h40, 32'hFFFFFFFF, 32'h00000000},
      '{1'b0, 8'h40, 32'h00000000, 32'h00000000},
      '{1'b1, 8'h41, 32'hFFFFFFFF, 32'h00000000},
      '{1'b0, 8'h41, 32'h00000000, 32'h00000000},
      '{1'b1, 8'h42, 32'hFFFFFFFF, 32'h00000000}
   };

   // ****************************************************************
   // clock, design and partner
   // ****************************************************************
   always #25 sys_clk_in = ~sys_clk_in;

   sfp_queue_stats uut (
      .sys_clk_in     (sys_clk_in),
      .srst_in        (srst_in),
      .reg_req_in     (req),
      .reg_rdata_out  (rdata),
      .reg_ack_out    (ack),
      .queue_flush_in (flush),
      .htx_in         (htx),
      .qev_in         (qev),
      .sizes_out      (sizes)
   );

   sfp_host_model host (
      .sys_clk_in   (sys_clk_in),
      .reg_req_out  (req),
      .reg_rdata_in (rdata),
      .reg_ack_in   (ack),
      .flush_out    (flush)
   );

   // ****************************************************************
   // tasks
   // ****************************************************************
   // compare one 32-bit result
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // read one register and compare, ack included
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      host.xfer(1'b0, a, 32'h00000000, q, k);
      chk("ack", 32'h00000001, {31'h00000000, k});
      chk($sformatf("reg %h", a), e, q);
   endtask : rd

   // one host frame of n half-words, one beat a cycle
   task automatic send(input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge sys_clk_in);
         #1;
         htx = '{sof: (i == 0), hw: 1'b1, eof: (i == n - 1), len: 14'(n)};
      end
      @(posedge sys_clk_in);
      #1;
      htx = '0;
   endtask : send

   // one cycle of queue events
   task automatic ev(input logic [2:0] v);
      @(posedge sys_clk_in);
      #1;
      qev = v;
      @(posedge sys_clk_in);
      #1;
      qev = '0;
   endtask : ev

   // verdict and end of run
   task automatic test_done;
      if (n_fail == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      repeat (2) @(posedge sys_clk_in);
      #1;
      srst_in = 1'b0;
      // table rows: reset values and refused writes
      foreach (rows[i])
      begin
         host.xfer(rows[i].w, rows[i].a, rows[i].d, q, k);
         chk("ack", 32'h00000001, {31'h00000000, k});
         chk($sformatf("row %0d", i), rows[i].e, q);
      end
      // flush opens the sizing register, reserved nibble reads zero
      host.resize(32'hF3210021);
      chk("sizes", 32'h03210021, sizes);
      rd(8'h3E, 32'h03210021);
      // traffic closes it again; host capacity is 1024 half-words
      send(4);
      rd(8'h40, 32'h00000004);
      host.xfer(1'b1, 8'h3E, 32'h01111111, q, k);
      rd(8'h3E, 32'h03210021);
      // one half-word too many: whole frame dropped, counted once
      send(1021);
      rd(8'h41, 32'h00000001);
      rd(8'h40, 32'h00000004);
      // exact fit at the boundary, then drain two
      send(1020);
      rd(8'h40, 32'h00000400);
      ev(3'b001);
      ev(3'b001);
      rd(8'h40, 32'h000003FE);
      // frame tally: three in, one out, one in and out together
      ev(3'b100);
      ev(3'b100);
      ev(3'b100);
      ev(3'b010);
      ev(3'b110);
      rd(8'h3F, 32'h00000002);
      // flush empties the queues but keeps the drop count
      host.flush();
      rd(8'h3F, 32'h00000000);
      rd(8'h40, 32'h00000000);
      rd(8'h41, 32'h00000001);
      // second reset in mid-run
      @(posedge sys_clk_in);
      #1;
      srst_in = 1'b1;
      repeat (2) @(posedge sys_clk_in);
      #1;
      srst_in = 1'b0;
      chk("sizes", 32'h02222222, sizes);
      rd(8'h3E, 32'h02222222);
      rd(8'h41, 32'h00000000);
      test_done();
   end

   // watchdog: a hang counts as a mismatch
   initial
   begin
      repeat (20000) @(posedge sys_clk_in);
      n_fail++;
      test_done();
   end

endmodule : tb
